// >>> shared/ajs_consts.svh
// Behaviour
// - after reset, write 20h to analog register 0-059h (always-one bit)
// - above 400 MHz input, write C0h, 40h, 04h to 0-039h, 0-03Ah, 0-056h
// - select page: 00h to 4-003h, then 69h, 6Ah or 68h to 4-004h
// - on JESD digital page, write 80h to 6-000h (K override)
// - reset serializer PLL: write 40h then 00h to 6-017h, analog page
// - apply main digital settings by writing 01h then 00h to 6-000h
// - on JESD digital page, write frames-per-multiframe K to 6-006h
// - while SYNCB is low the device sends K28.5 characters
// - after SYNCB goes high the device sends ILA, then sample data
// - wait at least 1 ms after power-up before the reset pulse
// - hardware reset pulse lasts at least 10 ns
// - wait at least 100 ns after reset before first port select
`ifndef AJS_CONSTS_SVH
`define AJS_CONSTS_SVH

`define AJS_CLK_NS 8
`define AJS_T_PU_US 1000
`define AJS_T_RST_NS 10
`define AJS_T_WR_NS 100
`define AJS_PU_CYC (`AJS_T_PU_US * 1000 / `AJS_CLK_NS)
`define AJS_RST_CYC ((`AJS_T_RST_NS + `AJS_CLK_NS - 1) / `AJS_CLK_NS)
`define AJS_WR_CYC ((`AJS_T_WR_NS + `AJS_CLK_NS - 1) / `AJS_CLK_NS)

`define AJS_SCK_DIV 2'h3
`define AJS_FRAME_LAST 5'h17
`define AJS_GAP_CYC 17'h00004
`define AJS_LAST_STEP 5'h11
`define AJS_HF_FIRST 5'h01
`define AJS_HF_SKIP 5'h04

`define AJS_A_CTRL 8'h00
`define AJS_A_STAT 8'h04
`define AJS_B_START 0
`define AJS_B_HF 1
`define AJS_K_LSB 8

`define AJS_BK_ANA 4'h0
`define AJS_BK_SEL 4'h4
`define AJS_BK_JESD 4'h6
`define AJS_R_ALWAYS1 12'h059
`define AJS_R_HF0 12'h039
`define AJS_R_HF1 12'h03a
`define AJS_R_HF2 12'h056
`define AJS_R_PG_LO 12'h003
`define AJS_R_PG_HI 12'h004
`define AJS_R_CTRL0 12'h000
`define AJS_R_PLL 12'h017
`define AJS_R_K 12'h006
`define AJS_V_ALWAYS1 8'h20
`define AJS_V_HF0 8'hc0
`define AJS_V_HF1 8'h40
`define AJS_V_HF2 8'h04
`define AJS_V_ZERO 8'h00
`define AJS_PG_JDIG 8'h69
`define AJS_PG_JANA 8'h6a
`define AJS_PG_MAIN 8'h68
`define AJS_V_KOVR 8'h80
`define AJS_V_PLLRST 8'h40
`define AJS_V_APPLY 8'h01

`endif

// >>> shared/ajs_pkg.sv
package ajs_pkg;
    typedef enum logic [3:0] {
        AJS_IDLE = 4'b0000,
        AJS_PWR = 4'b0001,
        AJS_RST = 4'b0010,
        AJS_WRW = 4'b0011,
        AJS_LOAD = 4'b0100,
        AJS_SHIFT = 4'b0101,
        AJS_GAP = 4'b0110,
        AJS_SYNC = 4'b0111,
        AJS_DONE = 4'b1000
    } ajs_st_t;

    typedef struct packed {
        ajs_st_t st;
        logic [16:0] cnt;
        logic [4:0] step;
        logic [23:0] sh;
        logic [4:0] nbit;
        logic [1:0] div;
        logic sclk;
        logic sen_n;
        logic dev_rst;
        logic syncb;
        logic hf;
        logic [7:0] k;
        logic done;
        logic ack;
        logic [31:0] rdat;
    } ajs_state_t;
endpackage

// >>> design/ajs_seq.sv
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "ajs_consts.svh"

module ajs_seq
    import ajs_pkg::*;
#(
    parameter int unsigned PU_CYCLES = `AJS_PU_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_synced_i,
    output logic dev_reset_o,
    output logic serial_port_select_n_o,
    output logic sclk_o,
    output logic sdata_o,
    output logic syncb_o
);

    // ==========================================================
    // device write list
    function automatic logic [23:0] ajs_word(input logic [4:0] step,
                                             input logic [7:0] k);
        logic [23:0] w;
        w = 24'h000000;
        case (step)
            5'h00: w = {`AJS_BK_ANA, `AJS_R_ALWAYS1, `AJS_V_ALWAYS1};
            5'h01: w = {`AJS_BK_ANA, `AJS_R_HF0, `AJS_V_HF0};
            5'h02: w = {`AJS_BK_ANA, `AJS_R_HF1, `AJS_V_HF1};
            5'h03: w = {`AJS_BK_ANA, `AJS_R_HF2, `AJS_V_HF2};
            5'h04: w = {`AJS_BK_SEL, `AJS_R_PG_LO, `AJS_V_ZERO};
            5'h05: w = {`AJS_BK_SEL, `AJS_R_PG_HI, `AJS_PG_JDIG};
            5'h06: w = {`AJS_BK_JESD, `AJS_R_CTRL0, `AJS_V_KOVR};
            5'h07: w = {`AJS_BK_SEL, `AJS_R_PG_LO, `AJS_V_ZERO};
            5'h08: w = {`AJS_BK_SEL, `AJS_R_PG_HI, `AJS_PG_JANA};
            5'h09: w = {`AJS_BK_JESD, `AJS_R_PLL, `AJS_V_PLLRST};
            5'h0a: w = {`AJS_BK_JESD, `AJS_R_PLL, `AJS_V_ZERO};
            5'h0b: w = {`AJS_BK_SEL, `AJS_R_PG_LO, `AJS_V_ZERO};
            5'h0c: w = {`AJS_BK_SEL, `AJS_R_PG_HI, `AJS_PG_MAIN};
            5'h0d: w = {`AJS_BK_JESD, `AJS_R_CTRL0, `AJS_V_APPLY};
            5'h0e: w = {`AJS_BK_JESD, `AJS_R_CTRL0, `AJS_V_ZERO};
            5'h0f: w = {`AJS_BK_SEL, `AJS_R_PG_LO, `AJS_V_ZERO};
            5'h10: w = {`AJS_BK_SEL, `AJS_R_PG_HI, `AJS_PG_JDIG};
            5'h11: w = {`AJS_BK_JESD, `AJS_R_K, k};
            default: w = 24'h000000;
        endcase
        return w;
    endfunction

    ajs_state_t s;
    ajs_state_t next_s;
    logic wr_ctrl;
    logic sck_en;

    assign wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && !s.ack
        && wb_adr_i == `AJS_A_CTRL;
    assign sck_en = s.div == `AJS_SCK_DIV;

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;
        next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
        next_s.div = sck_en ? 2'h0 : s.div + 2'h1;
        next_s.rdat = 32'h00000000;
        if (wb_adr_i == `AJS_A_CTRL) begin
            next_s.rdat = {16'h0000, s.k, 6'h00, s.hf, 1'b0};
        end else if (wb_adr_i == `AJS_A_STAT) begin
            next_s.rdat = {24'h000000, s.st, 1'b0, s.syncb, s.done,
                           s.st != AJS_IDLE && s.st != AJS_DONE};
        end
        if (wr_ctrl && wb_sel_i[0]) begin
            next_s.hf = wb_dat_i[`AJS_B_HF];
        end
        if (wr_ctrl && wb_sel_i[1]) begin
            next_s.k = wb_dat_i[`AJS_K_LSB +: 8];
        end
        case (s.st)
            AJS_IDLE, AJS_DONE: begin
                if (wr_ctrl && wb_sel_i[0] && wb_dat_i[`AJS_B_START]) begin
                    next_s.st = AJS_PWR;
                    next_s.cnt = 17'(PU_CYCLES - 1);
                    next_s.done = 1'b0;
                    next_s.syncb = 1'b0;
                end
            end
            AJS_PWR: begin
                next_s.cnt = s.cnt - 17'h00001;
                if (s.cnt == 17'h00000) begin
                    next_s.st = AJS_RST;
                    next_s.dev_rst = 1'b1;
                    next_s.cnt = 17'(`AJS_RST_CYC - 1);
                end
            end
            AJS_RST: begin
                next_s.cnt = s.cnt - 17'h00001;
                if (s.cnt == 17'h00000) begin
                    next_s.st = AJS_WRW;
                    next_s.dev_rst = 1'b0;
                    next_s.cnt = 17'(`AJS_WR_CYC - 1);
                    next_s.step = 5'h00;
                end
            end
            AJS_WRW: begin
                next_s.cnt = s.cnt - 17'h00001;
                if (s.cnt == 17'h00000) begin
                    next_s.st = AJS_LOAD;
                end
            end
            AJS_LOAD: begin
                if (sck_en) begin
                    next_s.st = AJS_SHIFT;
                    next_s.sh = ajs_word(s.step, s.k);
                    next_s.sen_n = 1'b0;
                    next_s.sclk = 1'b0;
                    next_s.nbit = 5'h00;
                end
            end
            AJS_SHIFT: begin
                if (sck_en && !s.sclk) begin
                    next_s.sclk = 1'b1;
                end else if (sck_en) begin
                    next_s.sclk = 1'b0;
                    next_s.sh = {s.sh[22:0], 1'b0};
                    next_s.nbit = s.nbit + 5'h01;
                    if (s.nbit == `AJS_FRAME_LAST) begin
                        next_s.st = AJS_GAP;
                        next_s.sen_n = 1'b1;
                        next_s.cnt = `AJS_GAP_CYC;
                    end
                end
            end
            AJS_GAP: begin
                next_s.cnt = s.cnt - 17'h00001;
                if (s.cnt == 17'h00000) begin
                    if (s.step == `AJS_LAST_STEP) begin
                        next_s.st = AJS_SYNC;
                    end else begin
                        next_s.st = AJS_LOAD;
                        if (s.step == 5'h00 && !s.hf) begin
                            next_s.step = `AJS_HF_SKIP;
                        end else begin
                            next_s.step = s.step + 5'h01;
                        end
                    end
                end
            end
            // syncb held low, release on sync
            AJS_SYNC: begin
                if (rx_synced_i) begin
                    next_s.syncb = 1'b1;
                    next_s.done = 1'b1;
                    next_s.st = AJS_DONE;
                end
            end
            default: next_s.st = AJS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.st <= AJS_IDLE;
            s.sen_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;
    assign dev_reset_o = s.dev_rst;
    assign serial_port_select_n_o = s.sen_n;
    assign sclk_o = s.sclk;
    assign sdata_o = s.sh[23];
    assign syncb_o = s.syncb;

    // ==========================================================
    // checks
    logic [7:0] since_rst;
    always_ff @(posedge clk_i) begin
        if (rst_i || s.dev_rst) begin
            since_rst <= 8'h00;
        end else if (since_rst != 8'hff) begin
            since_rst <= since_rst + 8'h01;
        end
    end

    property p_pu_wait;
        @(posedge clk_i) disable iff (rst_i)
        $rose(dev_reset_o) |-> $past(s.st) == AJS_PWR && $past(s.cnt) == 0;
    endproperty
    a_pu_wait: assert property (p_pu_wait) else $error("reset early");

    property p_rst_width;
        @(posedge clk_i) disable iff (rst_i)
        $rose(dev_reset_o) |-> dev_reset_o[*2];
    endproperty
    a_rst_width: assert property (p_rst_width) else $error("short rst");

    property p_wr_delay;
        @(posedge clk_i) disable iff (rst_i)
        $fell(serial_port_select_n_o) |-> since_rst >= 8'(`AJS_WR_CYC);
    endproperty
    a_wr_delay: assert property (p_wr_delay) else $error("early sel");

    property p_sync_low;
        @(posedge clk_i) disable iff (rst_i)
        (s.st != AJS_DONE) |-> !syncb_o;
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("syncb high");

    sequence s_synced;
        s.st == AJS_SYNC && rx_synced_i;
    endsequence
    property p_sync_rel;
        @(posedge clk_i) disable iff (rst_i)
        $rose(syncb_o) |-> $past(s.st) == AJS_SYNC && $past(rx_synced_i);
    endproperty
    a_sync_rel: assert property (p_sync_rel) else $error("bad release");

    property p_sync_now;
        @(posedge clk_i) disable iff (rst_i)
        s_synced |=> syncb_o && s.done;
    endproperty
    a_sync_now: assert property (p_sync_now) else $error("no release");

    property p_frame_gap;
        @(posedge clk_i) disable iff (rst_i)
        $rose(serial_port_select_n_o) |-> serial_port_select_n_o[*5];
    endproperty
    a_frame_gap: assert property (p_frame_gap) else $error("no gap");

    property p_pll_pair;
        @(posedge clk_i) disable iff (rst_i)
        s.st == AJS_GAP && s.step == 5'h09 && s.cnt == 17'h00000
            |=> s.step == 5'h0a;
    endproperty
    a_pll_pair: assert property (p_pll_pair) else $error("pll pair");

    property p_pll_set;
        @(posedge clk_i) disable iff (rst_i)
        $fell(serial_port_select_n_o) && s.step == 5'h09
            |-> s.sh == {`AJS_BK_JESD, `AJS_R_PLL, `AJS_V_PLLRST};
    endproperty
    a_pll_set: assert property (p_pll_set) else $error("pll set");

    property p_pll_clr;
        @(posedge clk_i) disable iff (rst_i)
        $fell(serial_port_select_n_o) && s.step == 5'h0a
            |-> s.sh == {`AJS_BK_JESD, `AJS_R_PLL, `AJS_V_ZERO};
    endproperty
    a_pll_clr: assert property (p_pll_clr) else $error("pll clear");

    property p_hf_skip;
        @(posedge clk_i) disable iff (rst_i)
        s.st == AJS_GAP && s.step == 5'h00 && s.cnt == 17'h00000 && !s.hf
            |=> s.step == `AJS_HF_SKIP;
    endproperty
    a_hf_skip: assert property (p_hf_skip) else $error("hf skip");

    property p_hf_take;
        @(posedge clk_i) disable iff (rst_i)
        s.st == AJS_GAP && s.step == 5'h00 && s.cnt == 17'h00000 && s.hf
            |=> s.step == `AJS_HF_FIRST;
    endproperty
    a_hf_take: assert property (p_hf_take) else $error("hf take");

    property p_k_word;
        @(posedge clk_i) disable iff (rst_i)
        $fell(serial_port_select_n_o) && s.step == `AJS_LAST_STEP
            |-> s.sh == {`AJS_BK_JESD, `AJS_R_K, s.k};
    endproperty
    a_k_word: assert property (p_k_word) else $error("k word");

    property p_sclk_idle;
        @(posedge clk_i) disable iff (rst_i)
        serial_port_select_n_o |-> !sclk_o;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("sclk");

    property p_apply;
        @(posedge clk_i) disable iff (rst_i)
        $fell(serial_port_select_n_o) && s.step == 5'h0d
            |-> s.sh == {`AJS_BK_JESD, `AJS_R_CTRL0, `AJS_V_APPLY};
    endproperty
    a_apply: assert property (p_apply) else $error("apply word");

    property p_first;
        @(posedge clk_i) disable iff (rst_i)
        $fell(serial_port_select_n_o) && s.step == 5'h00
            |-> s.sh == {`AJS_BK_ANA, `AJS_R_ALWAYS1, `AJS_V_ALWAYS1};
    endproperty
    a_first: assert property (p_first) else $error("first word");

endmodule

// >>> tb/ajs_dev_model.sv
`timescale 1ns/10ps
module ajs_dev_model (
    input wire logic clk_i,
    input wire logic dev_reset_i,
    input wire logic sel_n_i,
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic syncb_i,
    input wire logic hold_i,
    output logic rx_synced_o
);
    logic [23:0] sh;
    logic [23:0] frames[$];
    logic [7:0] regs[int];
    logic [7:0] page = 8'h00;
    logic [1:0] lane = 2'h0;
    logic pll_rst = 1'b0;
    int n = 0;
    int nbad = 0;
    int apply_cnt = 0;
    int kcnt = 0;

    function automatic logic [7:0] get(input int key);
        return regs.exists(key) ? regs[key] : 8'h00;
    endfunction

    task automatic store(input logic [23:0] f);
        int key;
        frames.push_back(f);
        if (f[23:8] == 16'h4004)
            page = f[7:0];
        key = {f[23:20], (f[23:20] == 4'h6) ? page : 8'h00, f[19:8]};
        if (key == 32'h668000 && get(key) == 8'h01 && f[7:0] == 8'h00)
            apply_cnt++;
        regs[key] = f[7:0];
        pll_rst = get(32'h66a017) == 8'h40;
    endtask

    // ==========
    // serial port
    always @(posedge sclk_i or posedge sel_n_i) begin
        if (sel_n_i) begin
            if (n == 24)
                store(sh);
            else if (n != 0)
                nbad++;
            n = 0;
        end else begin
            sh = {sh[22:0], sdata_i};
            n++;
        end
    end

    always @(posedge dev_reset_i) begin
        regs.delete();
        page = 8'h00;
        apply_cnt = 0;
        pll_rst = 1'b0;
    end

    // ==========
    // lanes and receiver
    // fixed link, comma then ila
    always @(posedge clk_i) begin
        if (dev_reset_i || !syncb_i) begin
            lane <= 2'h0;
            kcnt <= (dev_reset_i) ? 0 : ((kcnt < 8) ? kcnt + 1 : kcnt);
        end else if (lane == 2'h0) begin
            lane <= 2'h1;
        end else begin
            lane <= 2'h2;
        end
    end
    assign rx_synced_o = (kcnt == 8) && !hold_i;
endmodule

// >>> tb/test_ajs_seq.sv
`timescale 1ns/10ps
module test_ajs_seq;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic hold = 1'b1;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic wb_ack, rx_synced, dev_rst, sel_n, sclk, sdata, syncb;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [23:0] tbl [18] = '{24'h005920, 24'h0039c0, 24'h003a40,
        24'h005604, 24'h400300, 24'h400469, 24'h600080, 24'h400300,
        24'h40046a, 24'h601740, 24'h601700, 24'h400300, 24'h400468,
        24'h600001, 24'h600000, 24'h400300, 24'h400469, 24'h600600};

    ajs_seq #(.PU_CYCLES(20)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .rx_synced_i(rx_synced),
        .dev_reset_o(dev_rst), .serial_port_select_n_o(sel_n),
        .sclk_o(sclk), .sdata_o(sdata), .syncb_o(syncb));
    ajs_dev_model i_dev (.clk_i(clk_i), .dev_reset_i(dev_rst),
        .sel_n_i(sel_n), .sclk_i(sclk), .sdata_i(sdata), .syncb_i(syncb),
        .hold_i(hold), .rx_synced_o(rx_synced));

    initial forever #4 clk_i = ~clk_i;

    // ==========
    // helpers
    task automatic results;
        $display("mismatches %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            results;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %h not %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] sel);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= sel;
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        check(n < 20, 1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // ==========
    // one full start-up
    task automatic run(input logic hf, input logic [7:0] k);
        int n, i, j;
        i_dev.frames.delete();
        hold <= 1'b1;
        wb(1'b1, 8'h00, {16'h0, k, 6'h0, hf, 1'b1}, 4'hf);
        n = 0;
        while (dev_rst !== 1'b1 && n < 500) begin
            @(posedge clk_i);
            n++;
        end
        check(n + 1 >= 20, 1);
        n = 0;
        while (dev_rst === 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        check(n >= 2, 1);
        n = 0;
        while (sel_n === 1'b1 && n < 500) begin
            @(posedge clk_i);
            n++;
        end
        check(n >= 13, 1);
        n = 0;
        while (i_dev.frames.size() < (hf ? 18 : 15) && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (40) @(posedge clk_i);
        check(i_dev.frames.size(), hf ? 18 : 15);
        j = 0;
        for (i = 0; i < 18; i++) begin
            if (hf || i < 1 || i > 3) begin
                check(i_dev.frames[j], (i == 17) ? {tbl[i][23:8], k} : tbl[i]);
                j++;
            end
        end
        check(i_dev.nbad, 0);
        check(i_dev.get(32'h000059), 8'h20);
        check(i_dev.get(32'h000056), hf ? 8'h04 : 8'h00);
        check(i_dev.page, 8'h69);
        check(i_dev.get(32'h669000), 8'h80);
        check({i_dev.pll_rst, i_dev.get(32'h66a017)}, 9'h000);
        check(i_dev.apply_cnt, 1);
        check(i_dev.get(32'h669006), k);
        check({syncb, i_dev.lane}, 3'h0);
        wb(1'b0, 8'h04, 32'h0, 4'hf);
        check(q[2:1], 2'b00);
        wb(1'b0, 8'h00, 32'h0, 4'hf);
        check(q[15:0], {k, 6'h0, hf, 1'b0});
        hold <= 1'b0;
        n = 0;
        while (syncb !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        @(posedge clk_i);
        check(i_dev.lane, 2'h1);
        @(posedge clk_i);
        check(i_dev.lane, 2'h2);
        wb(1'b0, 8'h04, 32'h0, 4'hf);
        check(q[7:1], 7'h43);
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({dev_rst, sel_n, syncb}, 3'b010);
        wb(1'b0, 8'h10, 32'h0, 4'hf);
        check(q, 32'h0);
        // only the K byte lane: start and hf must be ignored
        wb(1'b1, 8'h00, 32'h00000a03, 4'h2);
        wb(1'b0, 8'h04, 32'h0, 4'hf);
        check(q[7:0], 8'h00);
        wb(1'b0, 8'h00, 32'h0, 4'hf);
        check(q[15:0], 16'h0a00);
        run(1'b1, 8'h20);
        run(1'b0, 8'h1f);
        results;
    end
endmodule
